// [include/sipo_pkg.sv]
// sipo_pkg: constants shared by the serial-in parallel-out shifter and
// its capture fifo. assumes a single 250 MHz system clock domain.
//
// Contract
// - eight stages in a chain, each stage value always on its output
// - entered bit is the and of both serial inputs
// - each shift clock rising edge, reset inactive, loads first stage
// - same edge moves each stage to the next, last value dropped
// - clear beats everything; edges and data during clear change nothing (an edge within three clocks of clear falling still queues the cleared word)
package sipo_pkg;
  localparam int SIPO_STAGES = 8;
  localparam int SIPO_FIFO_DEPTH = 32;
  localparam int SIPO_SYNC_DEPTH = 3;
  localparam logic [SIPO_STAGES-1:0] SIPO_STAGE_RESET = 8'h00;
  // positions of the pin inputs in the synchroniser vectors
  localparam int SIPO_PIN_A = 0;
  localparam int SIPO_PIN_B = 1;
  localparam int SIPO_PIN_CLK = 2;
  localparam int SIPO_PIN_CLR = 3;
  localparam int SIPO_PINS = 4;
  localparam logic [SIPO_PINS-1:0] SIPO_PINS_RESET = 4'h0;
endpackage : sipo_pkg

// [hw/sipo_fifo.sv]
// sipo_fifo: word fifo with a registered output word and registered
// write ready. assumes one clock, depth a power of two.
`timescale 1ns/1ps
module sipo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
    $error("sipo_fifo: depth must be a power of two above one");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic ready_reg, ready_next, out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, pop_out, load;

  // the output word is a stage of its own so the consumer sees flops only
  always_comb begin
    pop_out = out_valid_reg & i_rd_ready;
    load = (count_reg != '0) & (~out_valid_reg | pop_out);
    push = i_wr_valid & ready_reg;
    wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = load ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next = (AW+1)'(count_reg + {{AW{1'b0}}, push}
                 - {{AW{1'b0}}, load});
    // ready is registered, so it is worked out from the next count, one cycle ahead
    ready_next = (count_next != (AW+1)'(DEPTH));
    out_valid_next = load | (out_valid_reg & ~pop_out);
    out_data_next = load ? mem[rd_ptr_reg] : out_data_reg;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  // storage has no reset; only words behind the pointers are ever read
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  assign o_wr_ready = ready_reg;
  assign o_rd_valid = out_valid_reg;
  assign o_rd_data = out_data_reg;
endmodule : sipo_fifo

// [hw/sipo_shifter.sv]
// sipo_shifter: eight-stage serial-in parallel-out shift register whose
// shift clock, serial inputs and clear arrive as pins; every shifted word
// is also queued in a fifo for a downstream consumer while the fifo has room.
// assumes pin levels stay put for several system clocks around each edge.
`timescale 1ns/1ps
module sipo_shifter
  import sipo_pkg::*;
#(
  parameter int STAGES = SIPO_STAGES,
  parameter int FIFO_DEPTH = SIPO_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_serial_in_a,
  input wire logic i_serial_in_b,
  input wire logic i_shift_clock,
  input wire logic i_master_clear_n,
  output logic [STAGES-1:0] o_stage_out,
  output logic [STAGES-1:0] o_word_data,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic o_capture_ready,
  output logic o_overflow
);
  if (STAGES != SIPO_STAGES) begin : g_check
    $error("sipo_shifter: stage count is fixed by the reset constant");
  end

  // pin synchroniser: three flops, a level counts once flop 2 and 3 agree
  logic [SIPO_PINS-1:0] sync1_reg, sync1_next;
  logic [SIPO_PINS-1:0] sync2_reg, sync2_next;
  logic [SIPO_PINS-1:0] sync3_reg, sync3_next;
  logic [SIPO_PINS-1:0] level_reg, level_next;
  // stage chain and capture state
  logic [STAGES-1:0] stage_reg, stage_next;
  logic push_reg, push_next;
  logic overflow_reg, overflow_next;
  logic clk_rise, clear_seen, shift_bit, stage_rst_n, fifo_ready;

  // settled level of a pin: follows the sync pair only when both agree
  function automatic logic sipo_settle(input logic s2, input logic s3,
                                       input logic held);
    sipo_settle = (s2 == s3) ? s3 : held;
  endfunction : sipo_settle

  // synchroniser next state; flop 1 feeds flop 2 and nothing else
  always_comb begin
    sync1_next = {i_master_clear_n, i_shift_clock,
                  i_serial_in_b, i_serial_in_a};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    for (int i = 0; i < SIPO_PINS; i++) begin
      level_next[i] = sipo_settle(sync2_reg[i], sync3_reg[i], level_reg[i]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= SIPO_PINS_RESET;
      sync2_reg <= SIPO_PINS_RESET;
      sync3_reg <= SIPO_PINS_RESET;
      level_reg <= SIPO_PINS_RESET;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      level_reg <= level_next;
    end
  end

  // edge and data decode. the clock level is tracked even during clear,
  // so a clock left high across clear does not fake an edge afterwards.
  // only the settled clear level gates edges: the raw pin would reach a
  // flop input unsynchronised. an edge within three clocks of clear
  // falling may still queue the cleared word; the stages stay low anyway
  always_comb begin
    clear_seen = ~level_next[SIPO_PIN_CLR];
    clk_rise = level_next[SIPO_PIN_CLK] & ~level_reg[SIPO_PIN_CLK]
               & ~clear_seen;
    // both data bits settle on the same delay as the clock edge
    shift_bit = level_next[SIPO_PIN_A] & level_next[SIPO_PIN_B];
  end

  // stage chain next values
  always_comb begin
    stage_next = stage_reg;
    if (clk_rise) begin
      stage_next = {stage_reg[STAGES-2:0], shift_bit};
    end
  end

  // clear acts straight on the stage flops, bypassing the synchroniser
  assign stage_rst_n = i_resetn & i_master_clear_n;

  always_ff @(posedge i_mclk or negedge stage_rst_n) begin
    if (!stage_rst_n) begin
      stage_reg <= SIPO_STAGE_RESET;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // capture: each shift queues the new word one cycle later. the pin clock
  // cannot be stalled, so a word offered to a full fifo is lost and flagged
  always_comb begin
    push_next = clk_rise;
    overflow_next = overflow_reg | (push_reg & ~fifo_ready);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      push_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      push_reg <= push_next;
      overflow_reg <= overflow_next;
    end
  end

  sipo_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_wr_valid(push_reg),
    .o_wr_ready(fifo_ready),
    .i_wr_data(stage_reg),
    .o_rd_valid(o_word_valid),
    .i_rd_ready(i_word_ready),
    .o_rd_data(o_word_data)
  );

  // plain always-driven outputs, no enable and no float state
  assign o_stage_out = stage_reg;
  assign o_capture_ready = fifo_ready;
  assign o_overflow = overflow_reg;
endmodule : sipo_shifter

// [tb/sipo_drv.sv]
// sipo_drv: pin-level model of the logic feeding the shifter's pins.
// assumes the shared mclk; pins change only just after its rising edge.
`timescale 1ns/1ps
module sipo_drv (
  input wire logic i_mclk,
  output logic o_ser_a,
  output logic o_ser_b,
  output logic o_sclk,
  output logic o_clr_n
);
  // idle levels: clock low, clear released
  initial begin
    o_ser_a = 1'h0;
    o_ser_b = 1'h0;
    o_sclk = 1'h0;
    o_clr_n = 1'h1;
  end
  // six mclk per phase, because the pin filter needs four to see a level
  task automatic shift(input logic a, input logic b);
    @(posedge i_mclk) o_ser_a <= a;
    o_ser_b <= b;
    repeat (6) @(posedge i_mclk);
    o_sclk <= 1'h1;
    repeat (6) @(posedge i_mclk);
    o_sclk <= 1'h0;
  endtask : shift
  // caller waits before the next shift once clear is released
  task automatic clear(input logic lvl);
    @(posedge i_mclk) o_clr_n <= lvl;
  endtask : clear
endmodule : sipo_drv

// [tb/sipo_shifter_chk.sv]
// sipo_shifter_chk: timing relations on the shifter's stage outputs.
// assumes it is bound into sipo_shifter; one mclk domain.
`timescale 1ns/1ps
module sipo_shifter_chk #(
  parameter int STAGES = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_serial_in_a,
  input wire logic i_serial_in_b,
  input wire logic i_shift_clock,
  input wire logic i_master_clear_n,
  input wire logic [STAGES-1:0] o_stage_out,
  input wire logic [STAGES-1:0] o_word_data,
  input wire logic o_word_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  a_clear_forces_zero: assert property (
    !i_master_clear_n |-> ~|o_stage_out) else $error("stages not cleared");
  a_release_stays_quiet: assert property (
    $rose(i_master_clear_n) |-> ~|o_stage_out ##1 ~|o_stage_out)
    else $error("stages moved around clear");
  a_chain_moves_up: assert property (
    i_master_clear_n && !$stable(o_stage_out) |->
    o_stage_out[STAGES-1:1] == $past(o_stage_out[STAGES-2:0]))
    else $error("chain did not move by one");
  a_entry_is_and: assert property (
    i_master_clear_n && !$stable(o_stage_out) |->
    o_stage_out[0] == $past(i_serial_in_a & i_serial_in_b, 3))
    else $error("first stage not the and of inputs");
  a_shift_on_rise: assert property (
    i_master_clear_n && !$stable(o_stage_out) |->
    $past(i_shift_clock, 3) && !$past(i_shift_clock, 5))
    else $error("stages moved without a clock rise");
  a_hold_when_idle: assert property (
    (i_master_clear_n && $stable(i_shift_clock))[*5] |->
    $stable(o_stage_out)) else $error("stages moved while idle");
  a_word_is_snapshot: assert property (
    $rose(o_word_valid) |-> o_word_data == $past(o_stage_out))
    else $error("queued word differs from stages");
  c_word: cover property ($rose(o_word_valid));
  c_clear_edge: cover property (!i_master_clear_n && $rose(i_shift_clock));
  c_shift: cover property (i_master_clear_n && !$stable(o_stage_out));
endmodule : sipo_shifter_chk
bind sipo_shifter sipo_shifter_chk #(.STAGES(STAGES)) i_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_serial_in_a(i_serial_in_a),
  .i_serial_in_b(i_serial_in_b), .i_shift_clock(i_shift_clock),
  .i_master_clear_n(i_master_clear_n), .o_stage_out(o_stage_out),
  .o_word_data(o_word_data), .o_word_valid(o_word_valid));

// [tb/sipo_shifter_tb.sv]
// sipo_shifter_tb: drives the pins through sipo_drv and checks stages,
// clear and the capture fifo. assumes sipo_pkg and a 4 ns mclk.
`timescale 1ns/1ps
module sipo_shifter_tb;
  import sipo_pkg::*;
  logic i_mclk, i_resetn, i_word_ready, a, b, sclk, clr_n;
  logic word_valid, cap_ready, ovf;
  logic [7:0] stage, word, exp;
  logic [7:0] q[$];
  int failures = 0;
  int samples_checked = 0;
  sipo_drv i_drv (.i_mclk(i_mclk), .o_ser_a(a), .o_ser_b(b), .o_sclk(sclk),
    .o_clr_n(clr_n));
  sipo_shifter i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_serial_in_a(a), .i_serial_in_b(b), .i_shift_clock(sclk),
    .i_master_clear_n(clr_n), .o_stage_out(stage), .o_word_data(word),
    .o_word_valid(word_valid), .i_word_ready(i_word_ready),
    .o_capture_ready(cap_ready), .o_overflow(ovf));
  initial begin
    i_mclk = 1'h0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  // one shift with its expected stage word kept for the fifo check
  task automatic step(input logic sa, input logic sb);
    i_drv.shift(sa, sb);
    exp = {exp[6:0], sa & sb};
    q.push_back(exp);
  endtask : step
  task automatic t_and_table();
    for (int k = 0; k < 6; k++) begin
      step(k[0] | k[2], k[1] | k[2]);
      chk("stage", exp, stage);
    end
  endtask : t_and_table
  task automatic t_clear();
    step(1'h1, 1'h1);
    i_drv.clear(1'h0);
    #1 chk("clear", 8'h00, stage);
    i_drv.shift(1'h1, 1'h1);
    chk("clear_edge", 8'h00, stage);
    i_drv.clear(1'h1);
    repeat (6) @(posedge i_mclk);
    exp = 8'h00;
    chk("released", exp, stage);
  endtask : t_clear
  // 34 shifts into a 33-word path with the consumer stalled
  task automatic t_fill();
    i_word_ready <= 1'h0;
    q.delete();
    for (int k = 0; k < 34; k++) step(k % 3 != 0, 1'h1);
    exp = q.pop_back();
    chk("overflow", 8'h01, {7'h00, ovf});
    chk("cap_ready", 8'h00, {7'h00, cap_ready});
    i_word_ready <= 1'h1;
    for (int n = 0; n < 200 && q.size() > 0; n++) begin
      @(negedge i_mclk);
      if (word_valid === 1'h1) chk("word", q.pop_front(), word);
    end
    chk("left", 8'h00, 8'(q.size()));
  endtask : t_fill
  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    i_resetn = 1'h0;
    i_word_ready = 1'h1;
    exp = 8'h00;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'h1;
    repeat (4) @(posedge i_mclk);
    t_and_table();
    t_clear();
    t_fill();
    print_verdict();
  end
  // the run needs about 2.4 us; eight times that means a hang
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule : sipo_shifter_tb
